/* design/core_interrupt_sequencer.sv */
/*
  Interrupt sequencer of an 8-bit core: external group detectors,
  peripheral request latches, fixed priority, context push, vector load,
  return, and wake-up from wait and halt. APB slave for its registers.
  Assumes pins and core strobes synchronous to clk, one-cycle core
  command strobes, and a core that stalls while coreBusy is high.
*/
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "cis_map.svh"

// Summary of operation
// RL1 - entry starts only at an instruction boundary; entry from wait or halt starts without one
// RL2 - entry pushes PC, X, A and CC
// RL3 - entry sets the global mask bit
// RL4 - then loads the selected source's vector
// RL5 - return pops context and clears the mask
// RL6 - maskable requests wait while mask set
// RL7 - fixed priority: reset, trap, groups, peripherals
// RL8 - trap enters regardless of the mask
// RL9 - reset and trap use the two top vectors
// RL10 - group vectors descend from group 0
// RL11 - any request wakes the core from wait
// RL12 - only groups and reset leave halt
// RL13 - group request cleared on handler entry
// RL14 - enabled pins of a group are ANDed
// RL15 - any low enabled pin masks the group
// RL16 - sensitivity comes from the polarity bits
// RL17 - 00 fall+low, 10 fall, 01 rise, 11 both
// RL18 - changing a pair clears its group requests
// RL19 - peripheral request needs mask clear and enable
// RL20 - software runs the peripheral clear sequence
// RL21 - clear sequence discards the latched request
// RL22 - one vector chosen per entry at boundary
module core_interrupt_sequencer
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // core sequencer
  input  wire coreCmd_t    coreCmd,
  output stackCtl_t        stackCtl,
  output logic             vecLoad,
  output logic      [15:0] vecAddr,
  output logic             maskBit,
  output logic             coreBusy,
  output logic             waitMode,
  output logic             haltMode,
  // request sources
  input  wire logic [15:0] extPin,
  input  wire logic [3:0]  perFlag,
  input  wire logic [3:0]  perClear
);

  seqRegs_t    q;
  seqRegs_t    d;
  logic [3:0]  extLvl;
  logic [3:0]  extEvt;
  logic [3:0]  extReq;
  logic [3:0]  perReq;
  logic [3:0]  polClr;
  logic [3:0]  entryClr;
  logic [3:0]  pick;
  logic [3:0]  wakePick;
  logic [31:0] rdMux;
  logic        rdHit;
  logic        apbAccess;
  logic        apbWrite;

  // event of one group from its combined level
  function automatic logic groupEvent(input logic [1:0] pol,
                                      input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (pol)
      2'b00:   groupEvent = fall | ~cur;
      2'b10:   groupEvent = fall;
      2'b01:   groupEvent = rise;
      2'b11:   groupEvent = rise | fall;
      default: groupEvent = 1'b0;
    endcase
  endfunction

  // fixed priority over trap, groups 0..3, then peripherals 0..3
  function automatic logic [3:0] pickSrc(input logic trap,
                                         input logic [3:0] ext,
                                         input logic [3:0] per);
    pickSrc = `CIS_SRC_NONE;
    for (int i = 3; i >= 0; i--) begin
      if (per[i]) begin
        pickSrc = `CIS_SRC_PER0 + 4'(i);
      end
    end
    for (int i = 3; i >= 0; i--) begin
      if (ext[i]) begin
        pickSrc = `CIS_SRC_EXT0 + 4'(i);
      end
    end
    if (trap) begin
      pickSrc = `CIS_SRC_TRAP;
    end
  endfunction

  function automatic logic [15:0] vecOf(input logic [3:0] src);
    case (src)
      4'h0:    vecOf = `CIS_VEC_RESET;
      4'h1:    vecOf = `CIS_VEC_TRAP;
      4'h2:    vecOf = `CIS_VEC_EXT0;
      4'h3:    vecOf = `CIS_VEC_EXT1;
      4'h4:    vecOf = `CIS_VEC_EXT2;
      4'h5:    vecOf = `CIS_VEC_EXT3;
      4'h6:    vecOf = `CIS_VEC_SPI;
      4'h7:    vecOf = `CIS_VEC_TIMA;
      4'h8:    vecOf = `CIS_VEC_TIMB;
      4'h9:    vecOf = `CIS_VEC_SCI;
      default: vecOf = `CIS_VEC_RESET;
    endcase
  endfunction

  // pin groups: AND of enabled pins, then edge or level detector
  for (genvar g = 0; g < 4; g++) begin : gExt
    logic [3:0] pins;
    logic [3:0] ena;
    logic [1:0] pol;
    assign pins = extPin[4*g +: 4];
    assign ena  = q.pinEna[4*g +: 4];
    assign pol  = (g < 2) ? q.misc[`CIS_POL_LO_POS +: 2]
                          : q.misc[`CIS_POL_HI_POS +: 2];
    assign extLvl[g] = &(pins | ~ena); // see RL14 see RL15
    assign extEvt[g] = groupEvent(pol, q.extPrev[g], extLvl[g]); // see RL16 see RL17
  end

  assign extReq    = q.extPend & ~{4{q.mask}}; // see RL6
  assign perReq    = q.perLatch & q.perEna & ~{4{q.mask}}; // see RL19
  assign pick      = pickSrc(coreCmd.trap, extReq, perReq); // see RL7 see RL22
  assign wakePick  = pickSrc(1'b0, q.extPend, q.perLatch & q.perEna);
  assign apbAccess = psel & penable & ~q.pready;
  assign apbWrite  = psel & penable & q.pready & pwrite;

  always_comb begin
    rdHit = 1'b1;
    case (paddr)
      `CIS_MISC_OFS:  rdMux = {24'h00_0000, q.misc};
      `CIS_PENA_OFS:  rdMux = {28'h000_0000, q.perEna};
      `CIS_PINEN_OFS: rdMux = {16'h0000, q.pinEna};
      `CIS_STAT_OFS:  rdMux = {23'h00_0000, q.mask, q.perLatch, q.extPend};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always_comb begin
    d              = q;
    d.stack.write  = 1'b0;
    d.stack.read   = 1'b0;
    d.vecLoad      = 1'b0;
    d.pready       = 1'b0;
    d.pslverr      = 1'b0;
    polClr         = 4'h0;
    entryClr       = 4'h0;

    // one wait state, then answer
    if (apbAccess) begin
      d.pready  = 1'b1;
      d.pslverr = ~rdHit;
      d.prdata  = rdMux;
    end
    if (apbWrite) begin
      case (paddr)
        `CIS_MISC_OFS: begin
          d.misc = pwdata[7:0];
          if (pwdata[`CIS_POL_LO_POS +: 2] != q.misc[`CIS_POL_LO_POS +: 2])
          begin
            polClr[1:0] = 2'b11; // see RL18
          end
          if (pwdata[`CIS_POL_HI_POS +: 2] != q.misc[`CIS_POL_HI_POS +: 2])
          begin
            polClr[3:2] = 2'b11; // see RL18
          end
        end
        `CIS_PENA_OFS:  d.perEna = pwdata[3:0];
        `CIS_PINEN_OFS: d.pinEna = pwdata[15:0];
        default: ;
      endcase
    end

    // software mask instructions
    if (coreCmd.maskSet) begin
      d.mask = 1'b1;
    end
    if (coreCmd.maskClr) begin
      d.mask = 1'b0;
    end

    case (q.state)
      ST_RSTVEC: begin
        d.vecLoad = 1'b1;
        d.vecAddr = vecOf(`CIS_SRC_RESET); // see RL9
        d.mask    = 1'b1;
        d.state   = ST_IDLE;
      end
      ST_IDLE: begin
        if (coreCmd.boundary) begin // see RL1
          if (coreCmd.trap) begin
            d.src   = `CIS_SRC_TRAP; // see RL8
            d.cnt   = 3'd0;
            d.state = ST_PUSH;
          end else if (coreCmd.return_from_handler_instr) begin
            d.cnt   = 3'd0;
            d.state = ST_POP;
          end else if (coreCmd.wait_for_irq_instr) begin
            d.mask  = 1'b0;
            d.state = ST_WAIT;
          end else if (coreCmd.halt) begin
            d.mask  = 1'b0;
            d.state = ST_HALT;
          end else if (pick != `CIS_SRC_NONE) begin
            d.src   = pick; // see RL22
            d.cnt   = 3'd0;
            d.state = ST_PUSH;
          end
        end
      end
      ST_PUSH: begin
        d.stack.write = 1'b1; // see RL2
        d.stack.sel   = q.cnt;
        if (q.cnt == `CIS_CTX_LAST) begin
          d.state = ST_VEC;
        end else begin
          d.cnt = q.cnt + 3'd1;
        end
      end
      ST_VEC: begin
        d.vecLoad = 1'b1;
        d.vecAddr = vecOf(q.src); // see RL4 see RL10
        d.mask    = 1'b1; // see RL3
        for (int i = 0; i < 4; i++) begin
          if (q.src == `CIS_SRC_EXT0 + 4'(i)) begin
            entryClr[i] = 1'b1; // see RL13
          end
        end
        d.state = ST_IDLE;
      end
      ST_POP: begin
        d.stack.read = 1'b1; // see RL5
        d.stack.sel  = `CIS_CTX_LAST - q.cnt;
        if (q.cnt == `CIS_CTX_LAST) begin
          d.mask  = 1'b0;
          d.state = ST_IDLE;
        end else begin
          d.cnt = q.cnt + 3'd1;
        end
      end
      ST_WAIT: begin
        if (wakePick != `CIS_SRC_NONE) begin
          d.src   = wakePick; // see RL11
          d.cnt   = 3'd0;
          d.state = ST_PUSH;
        end
      end
      ST_HALT: begin
        if (|q.extPend) begin
          d.src   = pickSrc(1'b0, q.extPend, 4'h0); // see RL12
          d.cnt   = 3'd0;
          d.state = ST_PUSH;
        end
      end
      default: d.state = ST_IDLE;
    endcase

    // set wins over every clear
    d.extPrev  = extLvl;
    d.extPend  = (q.extPend & ~polClr & ~entryClr) | extEvt;
    d.perLatch = (q.perLatch & ~perClear) | perFlag; // see RL21
    d.busy     = d.state != ST_IDLE;
    d.waitMode = d.state == ST_WAIT;
    d.haltMode = d.state == ST_HALT;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q          <= '0;
      q.state    <= ST_RSTVEC;
      q.mask     <= `CIS_MASK_RST;
      q.extPrev  <= `CIS_PREV_RST;
      q.misc     <= `CIS_MISC_RST;
      q.perEna   <= `CIS_PENA_RST;
      q.pinEna   <= `CIS_PINEN_RST;
      q.busy     <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata   = q.prdata;
  assign pready   = q.pready;
  assign pslverr  = q.pslverr;
  assign stackCtl = q.stack;
  assign vecLoad  = q.vecLoad;
  assign vecAddr  = q.vecAddr;
  assign maskBit  = q.mask;
  assign coreBusy = q.busy;
  assign waitMode = q.waitMode;
  assign haltMode = q.haltMode;

  // checks
  logic idleBnd;
  logic plainBnd;
  assign idleBnd  = q.state == ST_IDLE && coreCmd.boundary;
  assign plainBnd = idleBnd && !coreCmd.trap && !coreCmd.return_from_handler_instr &&
                    !coreCmd.wait_for_irq_instr && !coreCmd.halt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence seqPush;
    stackCtl.write [*5];
  endsequence
  sequence seqVector;
    vecLoad && maskBit;
  endsequence

  chk_entry_push_vec: assert property ( // see RL2
    $rose(stackCtl.write) |-> seqPush ##1 seqVector)
    else $error("entry did not push five bytes then load vector");
  chk_entry_sets_mask: assert property ( // see RL3
    $rose(stackCtl.write) |-> ##5 (vecLoad && maskBit))
    else $error("mask not set at vector load");
  chk_return_from_handler_instr_clears_mask: assert property ( // see RL5
    idleBnd && coreCmd.return_from_handler_instr && !coreCmd.trap |=>
      ##1 stackCtl.read [*5] ##1 !maskBit)
    else $error("return did not pop and clear mask");
  chk_masked_holds_off: assert property ( // see RL6
    plainBnd && q.mask |=> q.state == ST_IDLE)
    else $error("maskable entry while mask set");
  chk_trap_ignores_mask: assert property ( // see RL8
    idleBnd && coreCmd.trap |=>
      q.state == ST_PUSH && q.src == `CIS_SRC_TRAP)
    else $error("trap not entered");
  chk_group0_first: assert property ( // see RL7
    plainBnd && !q.mask && q.extPend[0] |=> ##6 vecAddr == `CIS_VEC_EXT0)
    else $error("group 0 not first");
  chk_wait_wakeup: assert property ( // see RL11
    q.state == ST_WAIT && |(q.perLatch & q.perEna) |=>
      q.state == ST_PUSH)
    else $error("wait not left on enabled request");
  chk_halt_stays: assert property ( // see RL12
    q.state == ST_HALT && q.extPend == 4'h0 |=> q.state == ST_HALT)
    else $error("halt left without group request");
  chk_entry_clears_group: assert property ( // see RL13
    q.state == ST_VEC && q.src == `CIS_SRC_EXT0 && !extEvt[0] |=>
      !q.extPend[0])
    else $error("group 0 request kept after entry");
  chk_pol_write_clears: assert property ( // see RL18
    apbWrite && paddr == `CIS_MISC_OFS &&
      pwdata[`CIS_POL_LO_POS +: 2] != q.misc[`CIS_POL_LO_POS +: 2] &&
      extEvt[1:0] == 2'b00 |=> q.extPend[1:0] == 2'b00)
    else $error("polarity change left group 0 or 1 pending");
  chk_per_clear_drops: assert property ( // see RL21
    |(perClear & ~perFlag) |=>
      (q.perLatch & $past(perClear & ~perFlag)) == 4'h0)
    else $error("clear sequence kept peripheral request");
  chk_per_needs_enable: assert property ( // see RL19
    plainBnd && !q.mask && q.extPend == 4'h0 &&
      (q.perLatch & q.perEna) == 4'h0 |=> q.state == ST_IDLE)
    else $error("entry without enabled request");

endmodule

/* design/cis_map.svh */
/*
  Address map, field positions, reset values, vectors and counts of the
  interrupt sequencer.
  Assumes APB byte addressing with one 32-bit word per register.
*/
`ifndef CIS_MAP_SVH
`define CIS_MAP_SVH

// register byte offsets
`define CIS_MISC_OFS      12'h020
`define CIS_PENA_OFS      12'h024
`define CIS_PINEN_OFS     12'h028
`define CIS_STAT_OFS      12'h02C

// miscellaneous register fields
`define CIS_POL_LO_POS    3
`define CIS_POL_HI_POS    6
`define CIS_MISC_RST      8'h00

// own register reset values
`define CIS_PENA_RST      4'h0
`define CIS_PINEN_RST     16'h0000
`define CIS_MASK_RST      1'b1
`define CIS_PREV_RST      4'hF

// status register fields
`define CIS_STAT_EXT_POS  0
`define CIS_STAT_PER_POS  4
`define CIS_STAT_MASK_POS 8

// vector addresses
`define CIS_VEC_RESET     16'hFFFE
`define CIS_VEC_TRAP      16'hFFFC
`define CIS_VEC_EXT0      16'hFFF6
`define CIS_VEC_EXT1      16'hFFF4
`define CIS_VEC_EXT2      16'hFFF2
`define CIS_VEC_EXT3      16'hFFF0
`define CIS_VEC_SPI       16'hFFEC
`define CIS_VEC_TIMA      16'hFFEA
`define CIS_VEC_TIMB      16'hFFE8
`define CIS_VEC_SCI       16'hFFE6

// source codes, lower code wins
`define CIS_SRC_RESET     4'h0
`define CIS_SRC_TRAP      4'h1
`define CIS_SRC_EXT0      4'h2
`define CIS_SRC_PER0      4'h6
`define CIS_SRC_NONE      4'hF

// context is five stack bytes: PCL, PCH, X, A, CC
`define CIS_CTX_LAST      3'd4

`endif

/* design/cis_pkg.sv */
/*
  Types of the interrupt sequencer: states, core command and stack
  strobe carriers, and the state record.
  Assumes cis_map.svh for all numeric constants.
*/
package cis_pkg;

  typedef enum logic [2:0] {
    ST_RSTVEC,
    ST_IDLE,
    ST_PUSH,
    ST_VEC,
    ST_POP,
    ST_WAIT,
    ST_HALT
  } seqState_t;

  // what the core reports about the instruction now finishing
  typedef struct packed {
    logic boundary;
    logic trap;
    logic return_from_handler_instr;
    logic wait_for_irq_instr;
    logic halt;
    logic maskSet;
    logic maskClr;
  } coreCmd_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [2:0] sel;
  } stackCtl_t;

  typedef struct packed {
    seqState_t   state;
    logic [2:0]  cnt;
    logic [3:0]  src;
    logic        mask;
    logic [3:0]  extPend;
    logic [3:0]  extPrev;
    logic [3:0]  perLatch;
    logic [7:0]  misc;
    logic [3:0]  perEna;
    logic [15:0] pinEna;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    stackCtl_t   stack;
    logic        vecLoad;
    logic [15:0] vecAddr;
    logic        busy;
    logic        waitMode;
    logic        haltMode;
  } seqRegs_t;

endpackage

/* test/core_model.sv */
/*
  Core sequencer model: issues one command per go pulse, counts and
  orders the stack strobes of each entry or return.
  Assumes the bench raises go for one cycle while coreBusy is low.
*/
`timescale 1ns/1ps
module core_model
  import cis_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // bench side
  input  wire logic       go,
  input  wire coreCmd_t   goCmd,
  // sequencer side
  input  wire stackCtl_t  stackCtl,
  output coreCmd_t        coreCmd,
  output logic      [2:0] pushCnt,
  output logic      [2:0] popCnt,
  output logic            seqErr
);
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      coreCmd <= '0;
      pushCnt <= '0;
      popCnt  <= '0;
      seqErr  <= 1'b0;
    end else begin
      // commands only at the end of an instruction
      coreCmd <= go ? goCmd : '0;
      if (go) begin
        pushCnt <= '0;
        popCnt  <= '0;
      end else if (stackCtl.write) begin
        pushCnt <= pushCnt + 3'h1;
        seqErr  <= seqErr | (stackCtl.sel != pushCnt);
      end else if (stackCtl.read) begin
        popCnt <= popCnt + 3'h1;
        seqErr <= seqErr | (stackCtl.sel != 3'h4 - popCnt);
      end
    end
  end
endmodule

/* test/core_interrupt_sequencer_test.sv */
/*
  Self-checking bench of the interrupt sequencer over APB and core model.
  Assumes the design answers APB with one wait state.
*/
`timescale 1ns/1ps
`include "cis_map.svh"
module core_interrupt_sequencer_test;
  import cis_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  stackCtl_t   stackCtl;
  logic        vecLoad, maskBit, coreBusy, waitMode, haltMode;
  logic [15:0] vecAddr, extPin;
  logic [3:0]  perFlag, perClear;
  logic        go, seqErr;
  coreCmd_t    goCmd, coreCmd;
  logic [2:0]  pushCnt, popCnt;
  int          errCount, checksDone;

  core_interrupt_sequencer core_interrupt_sequencer_i (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreCmd(coreCmd), .stackCtl(stackCtl),
    .vecLoad(vecLoad), .vecAddr(vecAddr), .maskBit(maskBit),
    .coreBusy(coreBusy), .waitMode(waitMode), .haltMode(haltMode),
    .extPin(extPin), .perFlag(perFlag), .perClear(perClear));
  core_model core_model_i (.clk(clk), .reset_n(reset_n), .go(go),
    .goCmd(goCmd), .stackCtl(stackCtl), .coreCmd(coreCmd),
    .pushCnt(pushCnt), .popCnt(popCnt), .seqErr(seqErr));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string w, input logic [31:0] s, e);
    checksDone++;
    if (s !== e) begin
      errCount++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic testDone();
    $display("mismatches %0d checks %0d", errCount, checksDone);
    if (errCount == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("register read", r, x);
  endtask

  task automatic cmd(input coreCmd_t c);
    @(posedge clk);
    go <= 1'b1;
    goCmd <= c;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic waitVec(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (vecLoad !== 1'b1 && n < 40);
    chk("vector", vecAddr, v);
    chk("push count", pushCnt, 3'h5);
    chk("mask on entry", maskBit, 1'b1);
    chk("stack order", seqErr, 1'b0);
    repeat (2) @(posedge clk);
  endtask

  task automatic ret();
    cmd(7'h50);
    repeat (10) @(posedge clk);
    chk("pop count", popCnt, 3'h5);
    chk("mask after return", maskBit, 1'b0);
  endtask

  task automatic idleBoundary();
    cmd(7'h40);
    repeat (8) @(posedge clk);
    chk("no entry", pushCnt, 3'h0);
  endtask

  task automatic pclr(input int i);
    @(posedge clk) perClear[i] <= 1'b1;
    @(posedge clk) perClear <= 4'h0;
  endtask

  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rdc(`CIS_MISC_OFS, 32'h0000_0000);
    rdc(`CIS_PENA_OFS, 32'h0000_0000);
    rdc(`CIS_PINEN_OFS, 32'h0000_0000);
    wr(`CIS_STAT_OFS, 32'h0000_00FF);
    rdc(`CIS_STAT_OFS, 32'h0000_0100);
    apb(1'b0, 12'h030, 32'h0000_0000, r, e);
    chk("unmapped error", e, 1'b1);
    chk("unmapped data", r, 32'h0000_0000);
  endtask

  task automatic t_mask();
    wr(`CIS_PINEN_OFS, 32'h0000_0001);
    cmd(7'h02);
    @(posedge clk) extPin[0] <= 1'b0;
    repeat (3) @(posedge clk);
    extPin[0] <= 1'b1;
    rdc(`CIS_STAT_OFS, 32'h0000_0101);
    idleBoundary();
    cmd(7'h01);
    cmd(7'h40);
    waitVec(`CIS_VEC_EXT0);
    rdc(`CIS_STAT_OFS, 32'h0000_0100);
    ret();
  endtask

  task automatic t_modes();
    logic [1:0] md [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic fe [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(`CIS_MISC_OFS, 32'(md[i]) << `CIS_POL_LO_POS);
      rdc(`CIS_STAT_OFS, 32'h0000_0000);
      @(posedge clk) extPin[0] <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(`CIS_STAT_OFS, 32'(fe[i]));
      @(posedge clk) extPin[0] <= 1'b1;
      repeat (3) @(posedge clk);
      rdc(`CIS_STAT_OFS, 32'h0000_0001);
    end
    wr(`CIS_MISC_OFS, 32'h0000_0010);
  endtask

  task automatic t_and();
    wr(`CIS_PINEN_OFS, 32'h0000_3011);
    wr(`CIS_MISC_OFS, 32'h0000_0050);
    @(posedge clk) extPin[13] <= 1'b0;
    @(posedge clk) extPin[12] <= 1'b0;
    @(posedge clk) extPin[12] <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`CIS_STAT_OFS, 32'h0000_0000);
    @(posedge clk) extPin[13] <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(`CIS_STAT_OFS, 32'h0000_0008);
    wr(`CIS_MISC_OFS, 32'h0000_0090);
    rdc(`CIS_STAT_OFS, 32'h0000_0000);
  endtask

  task automatic t_prio();
    wr(`CIS_PENA_OFS, 32'h0000_0001);
    @(posedge clk);
    extPin[4] <= 1'b0;
    extPin[12] <= 1'b0;
    perFlag[0] <= 1'b1;
    repeat (2) @(posedge clk);
    extPin <= 16'hFFFF;
    perFlag <= 4'h0;
    cmd(7'h02);
    cmd(7'h60);
    waitVec(`CIS_VEC_TRAP);
    ret();
    cmd(7'h40);
    waitVec(`CIS_VEC_EXT1);
    ret();
    cmd(7'h40);
    waitVec(`CIS_VEC_EXT3);
    ret();
    cmd(7'h40);
    waitVec(`CIS_VEC_SPI);
    pclr(0);
    ret();
  endtask

  task automatic t_per();
    wr(`CIS_PENA_OFS, 32'h0000_0000);
    @(posedge clk) perFlag[1] <= 1'b1;
    repeat (2) @(posedge clk);
    perFlag <= 4'h0;
    rdc(`CIS_STAT_OFS, 32'h0000_0020);
    idleBoundary();
    pclr(1);
    rdc(`CIS_STAT_OFS, 32'h0000_0000);
    wr(`CIS_PENA_OFS, 32'h0000_000C);
    cmd(7'h48);
    repeat (4) @(posedge clk);
    chk("wait mode", waitMode, 1'b1);
    @(posedge clk) perFlag[2] <= 1'b1;
    repeat (2) @(posedge clk);
    perFlag <= 4'h0;
    waitVec(`CIS_VEC_TIMB);
    pclr(2);
    ret();
  endtask

  task automatic t_halt();
    cmd(7'h44);
    @(posedge clk) perFlag[3] <= 1'b1;
    repeat (2) @(posedge clk);
    perFlag <= 4'h0;
    repeat (10) @(posedge clk);
    chk("halt holds", haltMode, 1'b1);
    chk("halt no push", pushCnt, 3'h0);
    chk("halt stalls core", coreBusy, 1'b1);
    @(posedge clk) extPin[0] <= 1'b0;
    @(posedge clk) extPin[0] <= 1'b1;
    waitVec(`CIS_VEC_EXT0);
    chk("halt left", haltMode, 1'b0);
    pclr(3);
    ret();
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    testDone();
  end

  initial begin
    {reset_n, psel, penable, pwrite, go} = '0;
    {paddr, pwdata, goCmd, perFlag, perClear} = '0;
    extPin = 16'hFFFF;
    errCount = 0;
    checksDone = 0;
    repeat (5) @(posedge clk);
    chk("mask in reset", maskBit, 1'b1);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset vector", vecAddr, `CIS_VEC_RESET);
    t_regs();
    t_mask();
    t_modes();
    t_and();
    t_prio();
    t_per();
    t_halt();
    testDone();
  end
endmodule
